// [t16_cpu_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ****
// cpu side: ahb-lite master of byte registers
// ****
module t16_cpu_model (
  // clock
  input wire logic hclk,
  // request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // answer
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // idle bus at time zero
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one single transfer, entered just after a rising edge
  task automatic xfer(input logic [5:0] idx, input logic wr, input logic [7:0] d,
                      output logic [7:0] q);
    haddr <= {24'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata[7:0];
    hwdata <= ~hwdata; // released data lines do not keep the value
  endtask : xfer
  // pairs never interleave, no interrupt code here
  task automatic wr16(input logic [5:0] lo, input logic [15:0] d);
    logic [7:0] q;
    xfer(lo + 6'h1, 1'b1, d[15:8], q);
    xfer(lo, 1'b1, d[7:0], q);
  endtask : wr16
  task automatic rd16(input logic [5:0] lo, output logic [15:0] q);
    xfer(lo, 1'b0, 8'h00, q[7:0]);
    xfer(lo + 6'h1, 1'b0, 8'h00, q[15:8]);
  endtask : rd16
endmodule : t16_cpu_model
`default_nettype wire

// [t16_edge.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// pin synchroniser, optional noise filter, edge pulse
// ****************************************************************
module t16_edge #(
  parameter int NC = t16_pkg::NC_SAMPLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pin and options
  input wire logic pin_raw,
  input wire logic rise_sel,
  input wire logic noise_cancel,
  // qualified edge
  output logic edge_evt
);
  import t16_pkg::*;

  typedef struct packed {
    logic [2:0] sync;   // three-stage synchroniser
    logic lvl;          // level once stages two and three agree
    logic [NC-1:0] hist; // last samples of the level
    logic filt;         // filtered level
    logic evt;          // edge pulse
  } t16_edge_t;

  t16_edge_t s_r, s_nxt;

  // sample each clock, qualify, detect the wanted edge
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync = {s_r.sync[1:0], pin_raw};
    if (s_r.sync[1] == s_r.sync[2]) begin
      s_nxt.lvl = s_r.sync[2];
    end
    s_nxt.hist = {s_r.hist[NC-2:0], s_r.lvl};
    if (!noise_cancel) begin
      s_nxt.filt = s_r.lvl;
    end else if (&s_r.hist) begin
      s_nxt.filt = 1'b1;
    end else if (~|s_r.hist) begin
      s_nxt.filt = 1'b0;
    end
    s_nxt.evt = (s_nxt.filt != s_r.filt) && (s_nxt.filt == rise_sel);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign edge_evt = s_r.evt;
endmodule : t16_edge
`default_nettype wire

// [t16_pkg.sv]
// ****************************************************************
// constants of the 16-bit timer
// ****************************************************************
package t16_pkg;
  // register indices, byte address is four times the index
  localparam int IDX_W = 6;
  localparam int ADDR_LSB = 2;
  localparam logic [5:0] IDX_CTRL_A = 6'h2F;
  localparam logic [5:0] IDX_CTRL_B = 6'h2E;
  localparam logic [5:0] IDX_CNT_H = 6'h2D;
  localparam logic [5:0] IDX_CNT_L = 6'h2C;
  localparam logic [5:0] IDX_CMPA_H = 6'h2B;
  localparam logic [5:0] IDX_CMPA_L = 6'h2A;
  localparam logic [5:0] IDX_CMPB_H = 6'h29;
  localparam logic [5:0] IDX_CMPB_L = 6'h28;
  localparam logic [5:0] IDX_CAPT_H = 6'h25;
  localparam logic [5:0] IDX_CAPT_L = 6'h24;
  localparam logic [5:0] IDX_MISC = 6'h30;
  localparam logic [5:0] IDX_FLAGS = 6'h38;
  localparam logic [5:0] IDX_MASK = 6'h39;
  // control a fields
  localparam int CA_COMA_HI = 7;
  localparam int CA_COMA_LO = 6;
  localparam int CA_COMB_HI = 5;
  localparam int CA_COMB_LO = 4;
  localparam int CA_PWM_HI = 1;
  localparam int CA_PWM_LO = 0;
  localparam logic [7:0] CA_WMASK = 8'hF3;
  // control b fields
  localparam int CB_NC = 7;
  localparam int CB_ES = 6;
  localparam int CB_CTC = 3;
  localparam int CB_CS_HI = 2;
  localparam int CB_CS_LO = 0;
  localparam logic [7:0] CB_WMASK = 8'hCF;
  localparam int MISC_ACE = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_CK = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRESC_W = 10;
  localparam int DIV8_BITS = 3;
  localparam int DIV64_BITS = 6;
  localparam int DIV256_BITS = 8;
  // pwm select and tops
  localparam logic [1:0] PWM_OFF = 2'h0;
  localparam logic [1:0] PWM_8 = 2'h1;
  localparam logic [1:0] PWM_9 = 2'h2;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  localparam int PWM_CMP_W = 10;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  // compare output modes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  // event flag positions
  localparam int FLAG_W = 4;
  localparam int FL_OVF = 0;
  localparam int FL_CMPA = 1;
  localparam int FL_CMPB = 2;
  localparam int FL_CAPT = 3;
  localparam int NC_SAMPLES = 4;
endpackage : t16_pkg

// [t16_prescale.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// free-running divider giving prescaled count ticks
// ****************************************************************
module t16_prescale #(
  parameter int WIDTH = t16_pkg::PRESC_W
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // selection and tick
  input wire logic [2:0] clk_sel,
  output logic tick
);
  import t16_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] div; // divider count
    logic tick;            // registered tick
  } t16_presc_t;

  t16_presc_t s_r, s_nxt;
  logic [WIDTH-1:0] ones;

  // tick when the selected low bits are all ones
  always_comb begin
    ones = s_r.div;
    s_nxt.div = s_r.div + 1'b1;
    unique case (clk_sel)
      CS_DIV8: s_nxt.tick = &ones[DIV8_BITS-1:0];
      CS_DIV64: s_nxt.tick = &ones[DIV64_BITS-1:0];
      CS_DIV256: s_nxt.tick = &ones[DIV256_BITS-1:0];
      CS_DIV1024: s_nxt.tick = &ones;
      default: s_nxt.tick = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule : t16_prescale
`default_nettype wire

// [t16_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module t16_timer (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pins
  input wire logic count_pin,
  input wire logic capture_pin,
  input wire logic comparator_output,
  output logic compare_out_a,
  output logic compare_out_a_oe,
  output logic compare_out_b,
  output logic compare_out_b_oe,
  // masked event requests
  output logic [t16_pkg::FLAG_W-1:0] timer_irq_req
);
  import t16_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic wr_pend;       // write data phase due
    logic rd_pend;       // read data phase due
    logic [IDX_W-1:0] idx; // latched register index
    logic hreadyout;     // bus ready
    logic hresp;         // always okay
    logic [7:0] rdata;   // read byte
    logic [7:0] ctrl_a;  // timer_control_a
    logic [7:0] ctrl_b;  // timer_control_b
    logic ace;           // comparator_capture_enable
    logic [FLAG_W-1:0] mask; // timer_irq_mask
    logic [FLAG_W-1:0] flags; // event flags
    logic [15:0] cnt;    // timer_count_value
    logic up;            // pwm direction
    logic moved;         // counter changed last edge
    logic ctc_pend;      // match a waiting for the next tick
    logic clr_now;       // clear counter this cycle
    logic [15:0] cmpa_buf; // compare_value_a as written
    logic [15:0] cmpa_act; // compare_value_a in use
    logic [15:0] cmpb_buf; // compare_value_b as written
    logic [15:0] cmpb_act; // compare_value_b in use
    logic [15:0] capt;   // capture_value
    logic [7:0] temp;    // shared byte
    logic out_a;         // compare_out_a level
    logic out_b;         // compare_out_b level
    logic oe_a;          // compare_out_a enable
    logic oe_b;          // compare_out_b enable
    logic [FLAG_W-1:0] irq; // masked flags
  } t16_state_t;

  t16_state_t s_r, s_nxt;

  // ****************************************************************
  // helpers
  // ****************************************************************

  // top value of the selected pwm width
  function automatic logic [15:0] top_of(input logic [1:0] sel);
    unique case (sel)
      PWM_8: top_of = TOP_8;
      PWM_9: top_of = TOP_9;
      default: top_of = TOP_10;
    endcase
  endfunction : top_of

  // pin level after a match
  function automatic logic pin_after(input logic [1:0] mode, input logic pwm,
                                     input logic up, input logic pin);
    if (pwm) begin
      if (!mode[1]) begin
        pin_after = pin;
      end else if (up) begin
        pin_after = (mode == COM_SET);
      end else begin
        pin_after = (mode == COM_CLEAR);
      end
    end else begin
      unique case (mode)
        COM_TOGGLE: pin_after = ~pin;
        COM_CLEAR: pin_after = 1'b0;
        COM_SET: pin_after = 1'b1;
        default: pin_after = pin;
      endcase
    end
  endfunction : pin_after

  // whether the mode connects the pin
  function automatic logic pin_drive(input logic [1:0] mode, input logic pwm);
    pin_drive = pwm ? mode[1] : (mode != COM_OFF);
  endfunction : pin_drive

  // ****************************************************************
  // tick sources
  // ****************************************************************
  logic presc_tick; // divided clock tick
  logic ext_evt;    // qualified count pin edge
  logic cap_evt;    // qualified capture edge
  logic cap_src;    // capture trigger source

  assign cap_src = s_r.ace ? comparator_output : capture_pin;

  t16_prescale #(
    .WIDTH(PRESC_W)
  ) u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_sel(s_r.ctrl_b[CB_CS_HI:CB_CS_LO]),
    .tick(presc_tick)
  );

  // count pin, rising when clock select low bit is one
  t16_edge #(
    .NC(NC_SAMPLES)
  ) u_count_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_raw(count_pin),
    .rise_sel(s_r.ctrl_b[CB_CS_LO]),
    .noise_cancel(1'b0),
    .edge_evt(ext_evt)
  );

  // capture trigger with optional filter
  t16_edge #(
    .NC(NC_SAMPLES)
  ) u_capt_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_raw(cap_src),
    .rise_sel(s_r.ctrl_b[CB_ES]),
    .noise_cancel(s_r.ctrl_b[CB_NC]),
    .edge_evt(cap_evt)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  logic tick;          // counter advances
  logic pwm;           // pwm selected
  logic ctc;           // clear on match a active
  logic arm;           // clear due on next tick
  logic eq_a;          // match a this cycle
  logic eq_b;          // match b this cycle
  logic [15:0] top;    // pwm top
  logic [7:0] wd;      // written byte
  logic [FLAG_W-1:0] fset; // flags raised
  logic [FLAG_W-1:0] fclr; // flags cleared by software
  logic [2:0] cs;      // clock select

  always_comb begin
    s_nxt = s_r;
    wd = hwdata[7:0];
    fset = '0;
    fclr = '0;
    cs = s_r.ctrl_b[CB_CS_HI:CB_CS_LO];
    pwm = (s_r.ctrl_a[CA_PWM_HI:CA_PWM_LO] != PWM_OFF);
    top = top_of(s_r.ctrl_a[CA_PWM_HI:CA_PWM_LO]);
    ctc = s_r.ctrl_b[CB_CTC] && !pwm;
    // count source
    unique case (cs)
      CS_STOP: tick = 1'b0;
      CS_CK: tick = 1'b1;
      CS_EXT_FALL, CS_EXT_RISE: tick = ext_evt;
      default: tick = presc_tick;
    endcase
    // matches only after the counter itself moved
    if (pwm) begin
      eq_a = s_r.moved && (s_r.cnt[PWM_CMP_W-1:0] == s_r.cmpa_act[PWM_CMP_W-1:0]);
      eq_b = s_r.moved && (s_r.cnt[PWM_CMP_W-1:0] == s_r.cmpb_act[PWM_CMP_W-1:0]);
    end else begin
      eq_a = s_r.moved && (s_r.cnt == s_r.cmpa_act);
      eq_b = s_r.moved && (s_r.cnt == s_r.cmpb_act);
    end
    arm = ctc && (eq_a || s_r.ctc_pend);
    s_nxt.ctc_pend = arm;
    s_nxt.moved = 1'b0;
    s_nxt.clr_now = 1'b0;

    // counter
    if (s_r.clr_now) begin
      s_nxt.cnt = CNT_ZERO;
      s_nxt.moved = 1'b1;
    end else if (tick) begin
      s_nxt.moved = 1'b1;
      if (pwm) begin
        if (s_r.up) begin
          if (s_r.cnt >= top) begin
            s_nxt.up = 1'b0;
            s_nxt.cnt = s_r.cnt - 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
          end
        end else if (s_r.cnt == CNT_ZERO) begin
          s_nxt.up = 1'b1;
          s_nxt.cnt = s_r.cnt + 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
        s_nxt.clr_now = arm;
        s_nxt.ctc_pend = 1'b0;
        fset[FL_OVF] = (s_r.cnt == CNT_MAX);
      end
    end
    if (!pwm) begin
      s_nxt.up = 1'b1;
    end

    // compare values in use
    if (!pwm || s_r.cnt == top) begin
      s_nxt.cmpa_act = s_r.cmpa_buf;
      s_nxt.cmpb_act = s_r.cmpb_buf;
    end

    // compare pins
    if (eq_a) begin
      s_nxt.out_a = pin_after(s_r.ctrl_a[CA_COMA_HI:CA_COMA_LO], pwm, s_r.up, s_r.out_a);
    end
    if (eq_b) begin
      s_nxt.out_b = pin_after(s_r.ctrl_a[CA_COMB_HI:CA_COMB_LO], pwm, s_r.up, s_r.out_b);
    end
    s_nxt.oe_a = pin_drive(s_r.ctrl_a[CA_COMA_HI:CA_COMA_LO], pwm);
    s_nxt.oe_b = pin_drive(s_r.ctrl_a[CA_COMB_HI:CA_COMB_LO], pwm);
    fset[FL_CMPA] = eq_a;
    fset[FL_CMPB] = eq_b;

    // capture
    if (cap_evt) begin
      s_nxt.capt = s_r.cnt;
      fset[FL_CAPT] = 1'b1;
    end

    // ahb-lite read data phase, one wait cycle
    s_nxt.hreadyout = 1'b1;
    s_nxt.wr_pend = 1'b0;
    s_nxt.rd_pend = 1'b0;
    if (s_r.rd_pend) begin
      unique case (s_r.idx)
        IDX_CTRL_A: s_nxt.rdata = s_r.ctrl_a & CA_WMASK;
        IDX_CTRL_B: s_nxt.rdata = s_r.ctrl_b & CB_WMASK;
        IDX_MISC: s_nxt.rdata = {7'h00, s_r.ace};
        IDX_FLAGS: s_nxt.rdata = {4'h0, s_r.flags};
        IDX_MASK: s_nxt.rdata = {4'h0, s_r.mask};
        IDX_CNT_L: begin
          s_nxt.rdata = s_r.cnt[7:0];
          s_nxt.temp = s_r.cnt[15:8];
        end
        IDX_CMPA_L: begin
          s_nxt.rdata = s_r.cmpa_buf[7:0];
          s_nxt.temp = s_r.cmpa_buf[15:8];
        end
        IDX_CMPB_L: begin
          s_nxt.rdata = s_r.cmpb_buf[7:0];
          s_nxt.temp = s_r.cmpb_buf[15:8];
        end
        IDX_CAPT_L: begin
          s_nxt.rdata = s_r.capt[7:0];
          s_nxt.temp = s_r.capt[15:8];
        end
        IDX_CNT_H, IDX_CMPA_H, IDX_CMPB_H, IDX_CAPT_H: begin
          s_nxt.rdata = s_r.temp;
        end
        default: s_nxt.rdata = 8'h00;
      endcase
    end

    // ahb-lite write data phase, written byte wins over counting
    if (s_r.wr_pend) begin
      unique case (s_r.idx)
        IDX_CTRL_A: s_nxt.ctrl_a = wd & CA_WMASK;
        IDX_CTRL_B: s_nxt.ctrl_b = wd & CB_WMASK;
        IDX_MISC: s_nxt.ace = wd[MISC_ACE];
        IDX_FLAGS: fclr = wd[FLAG_W-1:0];
        IDX_MASK: s_nxt.mask = wd[FLAG_W-1:0];
        IDX_CNT_H, IDX_CMPA_H, IDX_CMPB_H, IDX_CAPT_H: begin
          s_nxt.temp = wd;
        end
        IDX_CNT_L: begin
          s_nxt.cnt = {s_r.temp, wd};
          s_nxt.moved = 1'b0;
          s_nxt.clr_now = 1'b0;
          s_nxt.ctc_pend = 1'b0;
        end
        IDX_CMPA_L: s_nxt.cmpa_buf = {s_r.temp, wd};
        IDX_CMPB_L: s_nxt.cmpb_buf = {s_r.temp, wd};
        default: s_nxt.temp = s_r.temp;
      endcase
    end

    // address phase
    if (hsel && htrans[1] && hready) begin
      s_nxt.idx = haddr[ADDR_LSB+IDX_W-1:ADDR_LSB];
      if (hwrite) begin
        s_nxt.wr_pend = 1'b1;
      end else begin
        s_nxt.rd_pend = 1'b1;
        s_nxt.hreadyout = 1'b0;
      end
    end

    // flags, a new event beats a clear in the same cycle
    s_nxt.flags = (s_r.flags & ~fclr) | fset;
    s_nxt.irq = s_r.flags & s_r.mask;
    s_nxt.hresp = 1'b0;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.hreadyout <= 1'b1;
      s_r.up <= 1'b1;
      s_r.ctrl_a <= CTRL_RESET;
      s_r.ctrl_b <= CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state
  assign hreadyout = s_r.hreadyout;
  assign hresp = s_r.hresp;
  assign hrdata = {24'h000000, s_r.rdata};
  assign compare_out_a = s_r.out_a;
  assign compare_out_a_oe = s_r.oe_a;
  assign compare_out_b = s_r.out_b;
  assign compare_out_b_oe = s_r.oe_b;
  assign timer_irq_req = s_r.irq;
endmodule : t16_timer
`default_nettype wire

// [t16_timer_checker.sv]
`timescale 1ns/10ps
`default_nettype none
// ****
// bus-side checks of the timer
// ****
module t16_timer_checker (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata
);
  import t16_pkg::*;
  logic take; // transfer accepted
  logic rd_ph_r; // read data phase open
  logic [5:0] idx_r; // index of last transfer
  assign take = hsel && htrans[1] && hready;
  // track read data phases
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph_r <= 1'b0;
      idx_r <= 6'h00;
    end else begin
      if (take) idx_r <= haddr[7:2];
      rd_ph_r <= (take && !hwrite) || (rd_ph_r && !hreadyout);
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wr_no_wait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  rd_one_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  stall_cause_a: assert property ($fell(hreadyout) |-> $past(take) && !$past(hwrite))
    else $error("stall without read");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response");
  rdata_upper_a: assert property (rd_ph_r && hreadyout |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  rdata_hold_a: assert property (!rd_ph_r |=> $stable(hrdata))
    else $error("read data moved");
  resv_ctrl_a_a: assert property (rd_ph_r && hreadyout && idx_r == IDX_CTRL_A |-> hrdata[3:2] == 2'h0)
    else $error("reserved a bits set");
  resv_ctrl_b_a: assert property (rd_ph_r && hreadyout && idx_r == IDX_CTRL_B |-> hrdata[5:4] == 2'h0)
    else $error("reserved b bits set");
  unmapped_zero_a: assert property (rd_ph_r && hreadyout && idx_r[5:4] == 2'h0 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : t16_timer_checker
bind t16_timer t16_timer_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
`default_nettype wire

// [timer16_compare_capture_pwm_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module timer16_compare_capture_pwm_tb_top;
  import t16_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, oa, oa_oe, ob, ob_oe;
  logic count_pin = 1'b0, capture_pin = 1'b0, comparator_output = 1'b0;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, m;
  logic [3:0] irq;
  logic [15:0] v, q, mx, last;
  logic [7:0] b, c;
  logic [5:0] idx [14] = '{IDX_CTRL_A, IDX_CTRL_B, IDX_CNT_L, IDX_CNT_H, IDX_CMPA_L,
    IDX_CMPA_H, IDX_CMPB_L, IDX_CMPB_H, IDX_CAPT_L, IDX_CAPT_H, IDX_FLAGS, IDX_MASK,
    IDX_MISC, 6'h0C};
  // capture cases: edge, filter, comparator, hit, width
  logic [7:0] ctab [5] = '{8'h96, 8'h16, 8'hC2, 8'h5A, 8'hB6};
  int errors = 0, tests_run = 0, seed = 67, n, e;
  always #25 hclk = ~hclk;
  t16_cpu_model cpu_u (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
  t16_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .count_pin(count_pin),
    .capture_pin(capture_pin), .comparator_output(comparator_output),
    .compare_out_a(oa), .compare_out_a_oe(oa_oe), .compare_out_b(ob),
    .compare_out_b_oe(ob_oe), .timer_irq_req(irq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_in(input logic [15:0] got, input int lo, input int hi);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_in
  task automatic final_report;
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic w8(input logic [5:0] i, input logic [7:0] d);
    cpu_u.xfer(i, 1'b1, d, b);
  endtask : w8
  // cycles until the next change of pin a, seen at falling edges
  task automatic wait_chg;
    logic s;
    s = oa;
    n = 0;
    while (oa === s && n < 100) begin
      @(negedge hclk);
      n++;
    end
    @(posedge hclk); // next bus request starts after a rising edge
  endtask : wait_chg
  // high cycles of both compare pins over one 8-bit pwm period
  task automatic duty;
    n = 0;
    e = 0;
    repeat (510) begin
      @(negedge hclk);
      n += (oa === 1'b1);
      e += (ob === 1'b1);
    end
    @(posedge hclk);
  endtask : duty
  // counts expected after g clocks for a clock select code
  function automatic int exp_cnt(input logic [2:0] cs, input int g);
    case (cs)
      CS_CK: return g;
      CS_DIV8: return g / 8;
      CS_DIV64: return g / 64;
      CS_DIV256: return g / 256;
      CS_DIV1024: return g / 1024;
      default: return 0;
    endcase
  endfunction : exp_cnt
  // watchdog
  initial begin
    repeat (60000) @(posedge hclk);
    errors++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    w8(6'h0C, 8'hFF);
    foreach (idx[i]) begin
      cpu_u.xfer(idx[i], 1'b0, 8'h00, c);
      chk(c, 8'h00);
    end
    repeat (4) begin
      v = $random(seed);
      w8(IDX_CTRL_A, v[7:0]);
      cpu_u.xfer(IDX_CTRL_A, 1'b0, 8'h00, c);
      chk(c, v[7:0] & 8'hF3);
      w8(IDX_CTRL_B, v[15:8] & 8'hF8);
      cpu_u.xfer(IDX_CTRL_B, 1'b0, 8'h00, c);
      chk(c, v[15:8] & 8'hC8);
    end
    w8(IDX_CTRL_A, 8'h00);
    foreach (idx[i]) if (i >= 2 && i <= 6 && i[0] == 1'b0) begin
      v = $random(seed);
      cpu_u.wr16(idx[i], v);
      w8(idx[i] + 6'h1, ~v[15:8]);
      cpu_u.rd16(idx[i], q);
      chk(q, v);
    end
    for (int s = 0; s < 6; s++) begin
      cpu_u.wr16(IDX_CNT_L, 16'h0000);
      w8(IDX_CTRL_B, 8'(s));
      repeat (2048) @(posedge hclk);
      w8(IDX_CTRL_B, 8'h00);
      cpu_u.rd16(IDX_CNT_L, q);
      e = exp_cnt(3'(s), 2048);
      chk_in(q, e - (e > 0), e + 3);
    end
    for (int s = 6; s < 8; s++) begin
      cpu_u.wr16(IDX_CNT_L, 16'h0000);
      w8(IDX_CTRL_B, 8'(s));
      repeat (10) begin
        count_pin <= 1'b1; // transitions three clocks apart
        repeat (3) @(posedge hclk);
        count_pin <= 1'b0;
        repeat (3) @(posedge hclk);
      end
      repeat (8) @(posedge hclk);
      w8(IDX_CTRL_B, 8'h00);
      cpu_u.rd16(IDX_CNT_L, q);
      chk(q, 16'd10);
    end
    // mask stays clear while output modes change
    cpu_u.wr16(IDX_CMPA_L, 16'd20);
    cpu_u.wr16(IDX_CMPB_L, 16'd5);
    w8(IDX_CTRL_B, 8'h09);
    for (m = 0; m < 4; m++) begin
      w8(IDX_CTRL_A, {m[1:0], m[1:0], 4'h0}); // output enables follow the compare mode
      repeat (50) @(posedge hclk);
      chk({oa_oe, ob_oe}, {2{m != 0}});
      if (m >= 2) chk({oa, ob}, {2{m[0]}});
      if (m == 1) begin
        wait_chg();
        wait_chg();
        chk(16'(n), 16'd22);
      end
    end
    repeat (4) begin
      repeat ($unsigned($random(seed)) % 30) @(posedge hclk);
      cpu_u.rd16(IDX_CNT_L, q);
      chk_in(q, 0, 21);
    end
    cpu_u.xfer(IDX_FLAGS, 1'b0, 8'h00, c);
    chk(c & 8'h06, 8'h06);
    w8(IDX_MASK, 8'h02);
    repeat (2) @(posedge hclk);
    chk(irq, 4'h2);
    w8(IDX_CTRL_B, 8'h00);
    w8(IDX_FLAGS, 8'h0F);
    w8(IDX_MASK, 8'h01);
    repeat (2) @(posedge hclk);
    chk(irq, 4'h0);
    cpu_u.wr16(IDX_CNT_L, 16'hFFF0);
    w8(IDX_CTRL_B, 8'h01);
    repeat (30) @(posedge hclk);
    chk(irq, 4'h1);
    w8(IDX_CTRL_B, 8'h09);
    for (int p = 1; p < 4; p++) begin
      w8(IDX_CTRL_A, 8'(p));
      mx = 16'h0;
      repeat (8) begin
        repeat ($unsigned($random(seed)) % 1024) @(posedge hclk);
        cpu_u.rd16(IDX_CNT_L, q);
        chk_in(q, 0, (1 << (7 + p)) - 1);
        if (q > mx) mx = q;
      end
      chk_in(mx, 22, (1 << (7 + p)) - 1);
    end
    // 8-bit pwm, a non-inverted (high 2*c), b inverted (high 510-2*c)
    w8(IDX_CTRL_A, 8'hB1);
    cpu_u.wr16(IDX_CNT_L, 16'h0000);
    repeat (600) @(posedge hclk);
    duty();
    chk(16'(n), 16'd40);
    chk(16'(e), 16'd500);
    // new compare value applies from the next top on
    cpu_u.wr16(IDX_CMPA_L, 16'd50);
    repeat (600) @(posedge hclk);
    duty();
    chk(16'(n), 16'd100);
    w8(IDX_CTRL_A, 8'h00);
    w8(IDX_CTRL_B, 8'h00);
    last = 16'h0;
    foreach (ctab[i]) begin
      c = ctab[i];
      v = $random(seed);
      cpu_u.wr16(IDX_CNT_L, v);
      w8(IDX_MISC, {7'h0, c[5]});
      w8(IDX_CTRL_B, {c[6], c[7], 6'h00});
      if (c[5]) comparator_output <= !c[7];
      else capture_pin <= !c[7];
      repeat (10) @(posedge hclk);
      if (c[5]) comparator_output <= c[7];
      else capture_pin <= c[7];
      repeat (c[3:0]) @(posedge hclk);
      if (c[5]) comparator_output <= !c[7];
      else capture_pin <= !c[7];
      repeat (12) @(posedge hclk);
      cpu_u.rd16(IDX_CAPT_L, q);
      if (c[4]) last = v;
      chk(q, last);
    end
    final_report();
  end
endmodule : timer16_compare_capture_pwm_tb_top
`default_nettype wire
